//--- design/rtcirq_params.svh
// constants of the rtc interrupt logic and its register host
`ifndef RTCIRQ_PARAMS_SVH
`define RTCIRQ_PARAMS_SVH

// ----------------------------------------------------------------
// clocking
// ----------------------------------------------------------------
`define RTCIRQ_CLK_HZ 50000000
`define RTCIRQ_SRC_HZ 32
`define RTCIRQ_DIV_W 21
`define RTCIRQ_DIV32 `RTCIRQ_DIV_W'(`RTCIRQ_CLK_HZ / `RTCIRQ_SRC_HZ)
`define RTCIRQ_SUB_8HZ 2'h3
`define RTCIRQ_SUB_1HZ 5'h1F
`define RTCIRQ_SUB_HALF 6'h3F

// ----------------------------------------------------------------
// device register map
// ----------------------------------------------------------------
`define RTCIRQ_A_CTRL1 8'h00
`define RTCIRQ_A_IEN 8'h01
`define RTCIRQ_A_FLAG 8'h02
`define RTCIRQ_A_STAT 8'h03
`define RTCIRQ_A_SEC 8'h08
`define RTCIRQ_A_MIN 8'h09
`define RTCIRQ_A_HR 8'h0A
`define RTCIRQ_A_ALM_S 8'h10
`define RTCIRQ_A_ALM_M 8'h11
`define RTCIRQ_A_ALM_H 8'h12
`define RTCIRQ_A_TLO 8'h18
`define RTCIRQ_A_THI 8'h19

// control register bit positions
`define RTCIRQ_B_WE 0
`define RTCIRQ_B_TE 1
`define RTCIRQ_B_TAR 2
`define RTCIRQ_B_TD0 5
`define RTCIRQ_B_TD1 6
`define RTCIRQ_B_AEN 7

// reset values
`define RTCIRQ_RST_WE 1'b1

// watch limits
`define RTCIRQ_SEC_MAX 6'h3B
`define RTCIRQ_MIN_MAX 6'h3B
`define RTCIRQ_HR_MAX 5'h17
`define RTCIRQ_CNT_ONE 16'h0001

// ----------------------------------------------------------------
// host register map (byte addresses on axi4-lite)
// ----------------------------------------------------------------
`define RTCIRQ_H_ADDR 4'h0
`define RTCIRQ_H_WDATA 4'h4
`define RTCIRQ_H_GO 4'h8
`define RTCIRQ_H_STAT 4'hC
`define RTCIRQ_RESP_OKAY 2'h0
`define RTCIRQ_RESP_SLVERR 2'h2

`endif

//--- design/rtcirq_pkg.sv
// types shared by the rtc interrupt device and its host
`include "rtcirq_params.svh"
package rtcirq_pkg;

    typedef enum logic {
        RTCIRQ_IDLE = 1'b0,
        RTCIRQ_BUSY = 1'b1
    } rtcirq_link_t;

    typedef struct packed {
        logic [`RTCIRQ_DIV_W-1:0] div;
        logic [5:0] sub;
        logic [4:0] wsub;
        logic sq;
        logic we_bit;
        logic te;
        logic auto_reload_mode;
        logic [1:0] td;
        logic [4:0] ie;
        logic [4:0] flag;
        logic [2:0] stat;
        logic [15:0] tmr_n;
        logic [15:0] cnt;
        logic pend;
        logic [5:0] sec;
        logic [5:0] min;
        logic [4:0] hr;
        logic [2:0][7:0] alm;
        logic match_q;
        logic ack;
        logic [7:0] rdata;
    } rtcirq_dev_state_t;

    localparam rtcirq_dev_state_t RTCIRQ_DEV_RST = '{we_bit: `RTCIRQ_RST_WE, default: '0};

    typedef struct packed {
        logic aw_full;
        logic [3:0] awaddr;
        logic w_full;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        rtcirq_link_t lk;
        logic [7:0] cmd_addr;
        logic [7:0] cmd_wdata;
        logic cmd_we;
        logic [7:0] last_rdata;
        logic int_s1;
        logic int_s2;
    } rtcirq_host_state_t;

endpackage

//--- design/rtcirq_if.sv
// register link and open-drain interrupt line between rtc device and host
`timescale 1ns/100ps
interface rtcirq_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    logic int_o;
    logic int_oe;
    logic int_n;

    // external pull-up: the line is high unless the device pulls it down
    assign int_n = int_oe ? int_o : 1'b1;

    modport dev (input req, we, addr, wdata, output ack, rdata, int_o, int_oe);
    modport host (output req, we, addr, wdata, input ack, rdata, int_n);
endinterface

//--- design/rtcirq_dev.sv
// rtc interrupt device: countdown timer, alarm match, watch gate, interrupt pin
//
// What this block does
// - 16-bit countdown from two bytes; zero stops
// - rate select 32/8/1/0.5 Hz, run bit
// - first period lasts n source ticks
// - auto-reload adds one tick: n+1 later
// - timer reaching zero sets flag bit 1
// - timer enable low: no timer flag
// - timer flag holds until written zero
// - alarm field compared only when bit 7 set
// - first full match sets alarm flag bit 0
// - alarm enable low: alarm flag stays clear
// - alarm flag holds until written zero
// - continuing match does not set again
// - interrupt pin active low, open drain
// - five sources, flags 0..4, gated by enables
// - low-voltage 1: flag and status clear
// - low-voltage 2: flag and status clear
// - system reset: flag and status clear
// - enable and flag bits 7..5 read 0
// - watch enable gates 1 Hz, resets to 1
// - watch stopped: time writable, not counting
// - watch enable leaves square wave alone
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "rtcirq_params.svh"
module rtcirq_dev import rtcirq_pkg::*; #(
    parameter logic [`RTCIRQ_DIV_W-1:0] TICK_DIV = `RTCIRQ_DIV32
) (
    input wire logic aclk,            // system clock
    input wire logic aresetn,         // synchronous reset, active low
    rtcirq_if.dev link,               // register link and interrupt line
    input wire logic low_volt1_event, // one-cycle pulse, level 1 low voltage seen
    input wire logic low_volt2_event, // one-cycle pulse, level 2 low voltage seen
    input wire logic sysreset_event,  // one-cycle pulse, system reset executed
    output logic square_wave_out      // free-running 16 Hz square wave
);

    rtcirq_dev_state_t s;
    rtcirq_dev_state_t n;
    logic tick32;
    logic src_tick;
    logic sec_tick;
    logic match;
    logic any_en;
    logic t_zero;
    logic access;
    logic wr;
    logic [4:0] flag_keep;
    logic [4:0] stat_keep;
    logic [4:0] flag_set;
    logic [2:0] stat_set;
    logic [4:0] src;

    // ----------------------------------------------------------------
    // register read mux
    // ----------------------------------------------------------------
    function automatic logic [7:0] reg_read(input rtcirq_dev_state_t st, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `RTCIRQ_A_CTRL1: begin
                v[`RTCIRQ_B_TD1] = st.td[1];
                v[`RTCIRQ_B_TD0] = st.td[0];
                v[`RTCIRQ_B_TAR] = st.auto_reload_mode;
                v[`RTCIRQ_B_TE] = st.te;
                v[`RTCIRQ_B_WE] = st.we_bit;
            end
            `RTCIRQ_A_IEN: v = {3'h0, st.ie};
            `RTCIRQ_A_FLAG: v = {3'h0, st.flag};
            `RTCIRQ_A_STAT: v = {3'h0, st.stat, 2'h0};
            `RTCIRQ_A_SEC: v = {2'h0, st.sec};
            `RTCIRQ_A_MIN: v = {2'h0, st.min};
            `RTCIRQ_A_HR: v = {3'h0, st.hr};
            `RTCIRQ_A_ALM_S: v = st.alm[0];
            `RTCIRQ_A_ALM_M: v = st.alm[1];
            `RTCIRQ_A_ALM_H: v = st.alm[2];
            `RTCIRQ_A_TLO: v = st.tmr_n[7:0];
            `RTCIRQ_A_THI: v = st.tmr_n[15:8];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = s;
        access = link.req & ~s.ack;
        wr = access & link.we;
        n.ack = access;
        if (access) begin
            n.rdata = reg_read(s, link.addr);
        end

        // prescaler runs regardless of the watch gate
        tick32 = (s.div == TICK_DIV - 1'b1);
        n.div = tick32 ? '0 : s.div + 1'b1;
        if (tick32) begin
            n.sub = s.sub + 1'b1;
            n.sq = ~s.sq;
        end
        unique case (s.td)
            2'h0: src_tick = tick32;
            2'h1: src_tick = tick32 & (s.sub[1:0] == `RTCIRQ_SUB_8HZ);
            2'h2: src_tick = tick32 & (s.sub[4:0] == `RTCIRQ_SUB_1HZ);
            2'h3: src_tick = tick32 & (s.sub == `RTCIRQ_SUB_HALF);
        endcase

        // the second divider is held clear while stopped, so after a restart
        // the first second lands on the 32nd prescaler tick after the enabling write
        sec_tick = tick32 & s.we_bit & (s.wsub == `RTCIRQ_SUB_1HZ);
        if (!s.we_bit) begin
            n.wsub = '0;
        end else if (tick32) begin
            n.wsub = s.wsub + 1'b1;
        end
        if (sec_tick) begin
            if (s.sec == `RTCIRQ_SEC_MAX) begin
                n.sec = '0;
                if (s.min == `RTCIRQ_MIN_MAX) begin
                    n.min = '0;
                    n.hr = (s.hr == `RTCIRQ_HR_MAX) ? '0 : s.hr + 1'b1;
                end else begin
                    n.min = s.min + 1'b1;
                end
            end else begin
                n.sec = s.sec + 1'b1;
            end
        end

        // countdown: the reload tick only follows an expiry, never the start
        t_zero = 1'b0;
        if (s.te && src_tick && s.tmr_n != '0) begin
            if (s.pend) begin
                n.cnt = s.tmr_n;
                n.pend = 1'b0;
            end else if (s.cnt == `RTCIRQ_CNT_ONE) begin
                n.cnt = '0;
                t_zero = 1'b1;
                n.pend = s.auto_reload_mode;
            end else if (s.cnt != '0) begin
                n.cnt = s.cnt - 1'b1;
            end
        end

        // alarm: disabled fields always agree, at least one must be enabled
        any_en = s.alm[0][`RTCIRQ_B_AEN] | s.alm[1][`RTCIRQ_B_AEN] | s.alm[2][`RTCIRQ_B_AEN];
        match = any_en
            & (~s.alm[0][`RTCIRQ_B_AEN] | (s.alm[0][5:0] == s.sec))
            & (~s.alm[1][`RTCIRQ_B_AEN] | (s.alm[1][5:0] == s.min))
            & (~s.alm[2][`RTCIRQ_B_AEN] | (s.alm[2][4:0] == s.hr));
        n.match_q = match;

        // flags only set when their enable is on; status bits always record
        flag_set = {sysreset_event, low_volt2_event, low_volt1_event, t_zero,
            match & ~s.match_q} & s.ie;
        stat_set = {sysreset_event, low_volt2_event, low_volt1_event};
        flag_keep = 5'h1F;
        stat_keep = 5'h1F;

        // ----------------------------------------------------------------
        // register writes
        // ----------------------------------------------------------------
        if (wr) begin
            unique case (link.addr)
                `RTCIRQ_A_CTRL1: begin
                    n.we_bit = link.wdata[`RTCIRQ_B_WE];
                    n.te = link.wdata[`RTCIRQ_B_TE];
                    // rate and reload mode are frozen while running
                    if (!s.te) begin
                        n.td = {link.wdata[`RTCIRQ_B_TD1], link.wdata[`RTCIRQ_B_TD0]};
                        n.auto_reload_mode = link.wdata[`RTCIRQ_B_TAR];
                    end
                    if (link.wdata[`RTCIRQ_B_TE] && !s.te) begin
                        n.cnt = s.tmr_n;
                        n.pend = 1'b0;
                    end
                end
                `RTCIRQ_A_IEN: n.ie = link.wdata[4:0];
                `RTCIRQ_A_FLAG: flag_keep = link.wdata[4:0];
                `RTCIRQ_A_STAT: stat_keep = link.wdata[4:0];
                `RTCIRQ_A_SEC: n.sec = link.wdata[5:0];
                `RTCIRQ_A_MIN: n.min = link.wdata[5:0];
                `RTCIRQ_A_HR: n.hr = link.wdata[4:0];
                `RTCIRQ_A_ALM_S: n.alm[0] = link.wdata;
                `RTCIRQ_A_ALM_M: n.alm[1] = link.wdata;
                `RTCIRQ_A_ALM_H: n.alm[2] = link.wdata;
                `RTCIRQ_A_TLO: begin
                    if (!s.te && !s.auto_reload_mode) begin
                        n.tmr_n[7:0] = link.wdata;
                    end
                end
                `RTCIRQ_A_THI: begin
                    if (!s.te && !s.auto_reload_mode) begin
                        n.tmr_n[15:8] = link.wdata;
                    end
                end
                default: n.ie = s.ie;
            endcase
        end

        // a written 0 clears, a written 1 keeps, and a new event wins
        n.flag = (s.flag & flag_keep) | flag_set;
        n.stat = (s.stat & stat_keep[4:2]) | stat_set;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= RTCIRQ_DEV_RST;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // low-voltage and reset sources stay up until both flag and status clear
    assign src = s.ie & {s.flag[4:2] | s.stat, s.flag[1:0]};
    assign link.int_oe = |src;
    assign link.int_o = 1'b0;
    assign link.ack = s.ack;
    assign link.rdata = s.rdata;
    assign square_wave_out = s.sq;

endmodule

//--- design/rtcirq_host.sv
// host end: axi4-lite command registers driving the rtc register link
`timescale 1ns/100ps
`include "rtcirq_params.svh"
module rtcirq_host import rtcirq_pkg::*; (
    input wire logic aclk,                 // system clock
    input wire logic aresetn,              // synchronous reset, active low
    rtcirq_if.host link,                   // register link and interrupt line
    input wire logic [3:0] s_axi_awaddr,   // write address
    input wire logic s_axi_awvalid,        // write address valid
    output logic s_axi_awready,            // write address ready
    input wire logic [31:0] s_axi_wdata,   // write data
    input wire logic [3:0] s_axi_wstrb,    // write byte strobes
    input wire logic s_axi_wvalid,         // write data valid
    output logic s_axi_wready,             // write data ready
    output logic [1:0] s_axi_bresp,        // write response
    output logic s_axi_bvalid,             // write response valid
    input wire logic s_axi_bready,         // write response ready
    input wire logic [3:0] s_axi_araddr,   // read address
    input wire logic s_axi_arvalid,        // read address valid
    output logic s_axi_arready,            // read address ready
    output logic [31:0] s_axi_rdata,       // read data
    output logic [1:0] s_axi_rresp,        // read response
    output logic s_axi_rvalid,             // read data valid
    input wire logic s_axi_rready          // read data ready
);

    rtcirq_host_state_t s;
    rtcirq_host_state_t n;
    logic busy;
    logic [3:0] wa;
    logic [3:0] ra;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = s;
        busy = (s.lk == RTCIRQ_BUSY);
        wa = {s.awaddr[3:2], 2'h0};
        ra = {s_axi_araddr[3:2], 2'h0};
        // the interrupt line is a pin: two flops before use
        n.int_s1 = link.int_n;
        n.int_s2 = s.int_s1;

        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_full = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_full = 1'b1;
            n.wdata = s_axi_wdata[7:0];
            n.wstrb0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_full && s.w_full && !s.bvalid) begin
            n.aw_full = 1'b0;
            n.w_full = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `RTCIRQ_RESP_OKAY;
            unique case (wa)
                `RTCIRQ_H_ADDR: begin
                    if (busy) begin
                        n.bresp = `RTCIRQ_RESP_SLVERR;
                    end else if (s.wstrb0) begin
                        n.cmd_addr = s.wdata;
                    end
                end
                `RTCIRQ_H_WDATA: begin
                    if (busy) begin
                        n.bresp = `RTCIRQ_RESP_SLVERR;
                    end else if (s.wstrb0) begin
                        n.cmd_wdata = s.wdata;
                    end
                end
                `RTCIRQ_H_GO: begin
                    // a launch while a transfer is open would corrupt it
                    if (busy) begin
                        n.bresp = `RTCIRQ_RESP_SLVERR;
                    end else if (s.wstrb0) begin
                        n.cmd_we = s.wdata[0];
                        n.lk = RTCIRQ_BUSY;
                    end
                end
                `RTCIRQ_H_STAT: n.bresp = `RTCIRQ_RESP_SLVERR;
            endcase
        end

        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rresp = `RTCIRQ_RESP_OKAY;
            unique case (ra)
                `RTCIRQ_H_ADDR: n.rdata = {24'h0, s.cmd_addr};
                `RTCIRQ_H_WDATA: n.rdata = {24'h0, s.cmd_wdata};
                `RTCIRQ_H_GO: n.rdata = {31'h0, s.cmd_we};
                `RTCIRQ_H_STAT: n.rdata = {16'h0, s.last_rdata, 6'h0, ~s.int_s2, busy};
            endcase
        end

        // link transfer ends on the device's acknowledge
        if (busy && link.ack) begin
            n.lk = RTCIRQ_IDLE;
            if (!s.cmd_we) begin
                n.last_rdata = link.rdata;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = ~s.aw_full & ~s.bvalid;
    assign s_axi_wready = ~s.w_full & ~s.bvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = ~s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign link.req = (s.lk == RTCIRQ_BUSY);
    assign link.we = s.cmd_we;
    assign link.addr = s.cmd_addr;
    assign link.wdata = s.cmd_wdata;

endmodule

//--- sim/rtcirq_asserts.sv
// concurrent checks on the register link and interrupt line of the rtc device
`timescale 1ns/100ps
`include "rtcirq_params.svh"
module rtcirq_asserts import rtcirq_pkg::*; (
    input wire logic aclk,        // system clock
    input wire logic aresetn,     // synchronous reset, active low
    input wire logic req,         // transfer open
    input wire logic we,          // write when high
    input wire logic [7:0] addr,  // device register address
    input wire logic [7:0] wdata, // write byte
    input wire logic ack,         // one-cycle answer
    input wire logic [7:0] rdata, // read byte
    input wire logic int_o,       // pin drive value
    input wire logic int_oe,      // pin pulled low when high
    input wire logic int_n        // resolved line
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ----------------------------------------------------------------
    // shadow of writable control bits
    // ----------------------------------------------------------------
    logic [4:0] ie_shadow;
    logic we_shadow;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ie_shadow <= 5'h00;
            we_shadow <= `RTCIRQ_RST_WE;
        end else if (req && we && !ack) begin
            if (addr == `RTCIRQ_A_IEN) ie_shadow <= wdata[4:0];
            if (addr == `RTCIRQ_A_CTRL1) we_shadow <= wdata[0];
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence s_taken;
        req && !ack;
    endsequence
    sequence s_answer;
        ack ##1 !ack;
    endsequence

    AST_ACK_ANSWER: assert property (s_taken |=> s_answer)
        else $error("ack not one pulse after request");
    AST_ACK_CAUSE: assert property (ack |-> $past(req) && !$past(ack))
        else $error("ack without a taken request");
    AST_INT_OD: assert property ((int_o == 1'b0) && (int_n == !int_oe))
        else $error("interrupt pin driven high");
    AST_REL_BY_WRITE: assert property ($fell(int_oe) |->
        $past(req && we && !ack && addr inside {`RTCIRQ_A_IEN, `RTCIRQ_A_FLAG, `RTCIRQ_A_STAT}))
        else $error("line released without a clearing write");
    AST_IEN_OFF: assert property (s_taken ##0
        (we && addr == `RTCIRQ_A_IEN && wdata[4:0] == 5'h00) |=> !int_oe)
        else $error("line still low after all enables cleared");
    AST_IEN_READ: assert property (ack && !we && addr == `RTCIRQ_A_IEN
        |-> rdata == {3'h0, ie_shadow})
        else $error("enable register readback wrong");
    AST_FLAG_HI: assert property (ack && !we
        && addr inside {`RTCIRQ_A_IEN, `RTCIRQ_A_FLAG} |-> rdata[7:5] == 3'h0)
        else $error("unimplemented bits read nonzero");
    AST_WE_READ: assert property (ack && !we && addr == `RTCIRQ_A_CTRL1
        |-> rdata[0] == we_shadow)
        else $error("watch enable readback wrong");
endmodule

//--- sim/rtcirq_tb.sv
// self-checking bench joining the rtc device and its axi host
`timescale 1ns/100ps
`include "rtcirq_params.svh"
module rtc_timer_alarm_irq_logic_tb import rtcirq_pkg::*;;
    localparam int D = 64;
    localparam int P = 4 * D; // one 8 Hz source tick
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [2:0] ev = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, sq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int failures = 0, cmp_count = 0, cyc = 0, sqc = 0;

    always #10 aclk = ~aclk;
    always @(sq) sqc++;

    rtcirq_if rtcirq_if_inst ();
    rtcirq_dev #(.TICK_DIV(21'(D))) rtcirq_dev_inst (.aclk(aclk), .aresetn(aresetn),
        .link(rtcirq_if_inst), .low_volt1_event(ev[0]), .low_volt2_event(ev[1]),
        .sysreset_event(ev[2]), .square_wave_out(sq));
    rtcirq_host rtcirq_host_inst (.aclk(aclk), .aresetn(aresetn), .link(rtcirq_if_inst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    rtcirq_asserts rtcirq_asserts_inst (.aclk(aclk), .aresetn(aresetn),
        .req(rtcirq_if_inst.req), .we(rtcirq_if_inst.we), .addr(rtcirq_if_inst.addr),
        .wdata(rtcirq_if_inst.wdata), .ack(rtcirq_if_inst.ack), .rdata(rtcirq_if_inst.rdata),
        .int_o(rtcirq_if_inst.int_o), .int_oe(rtcirq_if_inst.int_oe), .int_n(rtcirq_if_inst.int_n));

    // ----------------------------------------------------------------
    // report and bus tasks
    // ----------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            tally_and_finish();
        end
    end
    task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        chk("rresp", `RTCIRQ_RESP_OKAY, rresp);
        rready <= 1'b0;
    endtask
    // one device access; busy is polled so no launch is refused
    task dev(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [1:0] r;
        logic [31:0] s;
        wr(`RTCIRQ_H_ADDR, {24'h0, a}, r);
        wr(`RTCIRQ_H_WDATA, {24'h0, d}, r);
        wr(`RTCIRQ_H_GO, {31'h0, w}, r);
        do rd(`RTCIRQ_H_STAT, s); while (s[0] !== 1'b0);
        q = s[15:8];
    endtask
    task dw(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        dev(1'b1, a, d, q);
    endtask
    task dr(input logic [7:0] a, output logic [7:0] q);
        dev(1'b0, a, 8'h00, q);
    endtask
    task wait_int(output int t);
        while (rtcirq_if_inst.int_n !== 1'b0) @(posedge aclk);
        t = cyc;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] q;
        logic [1:0] r;
        int n, t0, t1, t2, t3, m, s, b;
        void'($urandom(78736));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        dr(`RTCIRQ_A_CTRL1, q); chk("ctrl1", 8'h01, q);
        dr(`RTCIRQ_A_FLAG, q); chk("flag", 8'h00, q);
        dr(8'h05, q); chk("unmapped", 8'h00, q);
        wr(`RTCIRQ_H_STAT, 32'h1, r); chk("stat write", `RTCIRQ_RESP_SLVERR, r);
        n = 3 + $urandom_range(2);
        dw(`RTCIRQ_A_IEN, 8'h02); dw(`RTCIRQ_A_TLO, 8'(n)); dw(`RTCIRQ_A_THI, 8'h00);
        t0 = cyc;
        dw(`RTCIRQ_A_CTRL1, 8'h27);
        wait_int(t1);
        chk("first period", 1, (t1 - t0 > (n - 1) * P) && (t1 - t0 <= n * P + 30));
        dr(`RTCIRQ_A_FLAG, q); chk("timer flag", 8'h02, q);
        dw(`RTCIRQ_A_FLAG, 8'hFF); dr(`RTCIRQ_A_FLAG, q); chk("flag ones", 8'h02, q);
        dw(`RTCIRQ_A_FLAG, 8'h00); chk("released", 1, rtcirq_if_inst.int_n);
        wait_int(t2); dw(`RTCIRQ_A_FLAG, 8'h00); wait_int(t3);
        chk("period 2", (n + 1) * P, t2 - t1);
        chk("period 3", (n + 1) * P, t3 - t2);
        dw(`RTCIRQ_A_FLAG, 8'h00); dw(`RTCIRQ_A_CTRL1, 8'h01); dw(`RTCIRQ_A_CTRL1, 8'h01);
        dw(`RTCIRQ_A_IEN, 8'h00); dw(`RTCIRQ_A_TLO, 8'h02); dw(`RTCIRQ_A_CTRL1, 8'h03);
        repeat (4 * D) @(posedge aclk);
        chk("no timer irq", 1, rtcirq_if_inst.int_n);
        dr(`RTCIRQ_A_FLAG, q); chk("no timer flag", 8'h00, q);
        // watch stopped, alarm on minute only
        m = 1 + $urandom_range(58);
        s = $urandom_range(58);
        dw(`RTCIRQ_A_CTRL1, 8'h00); dw(`RTCIRQ_A_SEC, 8'(s));
        t0 = sqc;
        repeat (4 * D) @(posedge aclk);
        chk("square", 4, sqc - t0);
        dr(`RTCIRQ_A_SEC, q); chk("sec held", 8'(s), q);
        dw(`RTCIRQ_A_ALM_S, 8'(s + 1)); dw(`RTCIRQ_A_ALM_M, 8'h80 | 8'(m));
        dw(`RTCIRQ_A_MIN, 8'(m)); dr(`RTCIRQ_A_FLAG, q); chk("alarm off", 8'h00, q);
        dw(`RTCIRQ_A_IEN, 8'h01); dw(`RTCIRQ_A_MIN, 8'(m - 1)); dw(`RTCIRQ_A_MIN, 8'(m));
        dr(`RTCIRQ_A_FLAG, q); chk("alarm flag", 8'h01, q);
        chk("alarm line", 0, rtcirq_if_inst.int_n);
        dw(`RTCIRQ_A_FLAG, 8'h00); chk("alarm clear", 1, rtcirq_if_inst.int_n);
        repeat (2 * D) @(posedge aclk);
        dr(`RTCIRQ_A_FLAG, q); chk("no re-set", 8'h00, q);
        // the three event sources, first masked then enabled
        for (int i = 0; i < 3; i++) begin
            b = i + 2;
            dw(`RTCIRQ_A_IEN, 8'h00);
            @(posedge aclk); ev[i] <= 1'b1; @(posedge aclk); ev[i] <= 1'b0;
            dr(`RTCIRQ_A_FLAG, q); chk("masked flag", 8'h00, q);
            dr(`RTCIRQ_A_STAT, q); chk("status", 8'(1 << b), q);
            dw(`RTCIRQ_A_STAT, 8'h00); dw(`RTCIRQ_A_IEN, 8'hE0 | 8'(1 << b));
            dr(`RTCIRQ_A_IEN, q); chk("enable", 8'(1 << b), q);
            @(posedge aclk); ev[i] <= 1'b1; @(posedge aclk); ev[i] <= 1'b0;
            repeat (2) @(posedge aclk);
            chk("event line", 0, rtcirq_if_inst.int_n);
            dw(`RTCIRQ_A_FLAG, 8'h00);
            chk("status holds", 0, rtcirq_if_inst.int_n);
            dw(`RTCIRQ_A_STAT, 8'h00);
            chk("both clear", 1, rtcirq_if_inst.int_n);
        end
        tally_and_finish();
    end
endmodule
